// File: rtl/eepr_port.sv
// serial memory device: three-wire port, array, write engine and read path
`timescale 1ns/1ps
`default_nettype none

module eepr_port #(
   parameter int WRITE_CYCLES = eepr_pkg::WRITE_CYCLES_DEFAULT
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // serial link
   input wire logic device_select,
   input wire logic serial_clock,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe,
   // strap
   input wire logic organisation_select
);
   logic [7:0] mem_array [eepr_pkg::ARRAY_BYTES];

   eepr_pkg::eepr_state_t state_reg;
   logic sk_q;
   logic cs_q;
   logic sk_rise;
   logic cs_rise;
   logic active_edge;
   logic [3:0] bit_cnt_reg;
   logic [1:0] op_reg;
   logic [10:0] addr_reg;
   logic [15:0] data_reg;
   logic org_reg;
   logic we_en_reg;
   logic status_armed_reg;
   logic launch_reg;
   logic read_start_reg;
   eepr_pkg::eepr_job_t job_reg;
   logic [10:0] a_next;
   logic [15:0] d_next;
   logic [1:0] ext_code;
   logic addr_last;
   logic data_last;
   logic busy_reg;
   logic [31:0] timer_reg;
   logic [11:0] idx_reg;
   logic wr_active;
   logic [10:0] wr_byte;
   logic [7:0] wr_val;
   logic fetch_on_reg;
   logic [10:0] fetch_addr_reg;
   eepr_pkg::eepr_word_t rd_word;
   logic buf_in_ready;
   logic buf_out_valid;
   logic [$bits(eepr_pkg::eepr_word_t)-1:0] buf_out_bits;
   eepr_pkg::eepr_word_t buf_word;
   logic pop;
   logic [15:0] shift_reg;
   logic [4:0] bits_left_reg;

   function automatic eepr_pkg::eepr_job_t mk_job(input logic bulk, input logic wide,
                                                  input logic [10:0] addr, input logic [15:0] data);
      eepr_pkg::eepr_job_t j;
      j.base = bulk ? 11'h000 : (wide ? {addr[9:0], 1'h0} : addr);
      j.len = bulk ? eepr_pkg::BULK_LEN : (wide ? eepr_pkg::LEN_X16 : eepr_pkg::LEN_X8);
      j.data = data;
      j.wide = wide;
      return j;
   endfunction

   // serial_clock is a plain sampled input, so edges are found against one flop
   assign sk_rise = serial_clock && !sk_q;
   assign cs_rise = device_select && !cs_q;
   assign active_edge = device_select && sk_rise;
   assign a_next = {addr_reg[9:0], serial_in};
   assign d_next = {data_reg[14:0], serial_in};
   assign ext_code = org_reg ? a_next[9:8] : a_next[10:9];
   assign addr_last = bit_cnt_reg == (org_reg ? eepr_pkg::ADDR_LAST_X16 : eepr_pkg::ADDR_LAST_X8);
   assign data_last = bit_cnt_reg == (org_reg ? eepr_pkg::DATA_LAST_X16 : eepr_pkg::DATA_LAST_X8);

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         sk_q <= 1'h0;
         cs_q <= 1'h0;
      end
      else
      begin
         sk_q <= serial_clock;
         cs_q <= device_select;
      end
   end

   // command sequencer
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state_reg <= eepr_pkg::ST_IDLE;
         bit_cnt_reg <= 4'h0;
         op_reg <= 2'h0;
         addr_reg <= 11'h000;
         data_reg <= 16'h0000;
         org_reg <= 1'h1;
         we_en_reg <= 1'h0;
         status_armed_reg <= 1'h0;
         launch_reg <= 1'h0;
         read_start_reg <= 1'h0;
         job_reg <= '0;
      end
      else
      begin
         launch_reg <= 1'h0;
         read_start_reg <= 1'h0;
         if (!device_select)
         begin
            state_reg <= eepr_pkg::ST_IDLE;
         end
         else if (cs_rise && status_armed_reg)
         begin
            state_reg <= eepr_pkg::ST_STATUS;
         end
         else if (active_edge)
         begin
            bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
            unique case (state_reg)
               eepr_pkg::ST_IDLE, eepr_pkg::ST_STATUS:
               begin
                  // start bits are refused while the array is still being written
                  if (serial_in && !busy_reg)
                  begin
                     state_reg <= eepr_pkg::ST_OP;
                     bit_cnt_reg <= 4'h0;
                     org_reg <= organisation_select;
                     status_armed_reg <= 1'h0;
                  end
               end
               eepr_pkg::ST_OP:
               begin
                  op_reg <= {op_reg[0], serial_in};
                  if (bit_cnt_reg == eepr_pkg::OP_LAST)
                  begin
                     state_reg <= eepr_pkg::ST_ADDR;
                     bit_cnt_reg <= 4'h0;
                  end
               end
               eepr_pkg::ST_ADDR:
               begin
                  addr_reg <= a_next;
                  if (addr_last)
                  begin
                     bit_cnt_reg <= 4'h0;
                     state_reg <= eepr_pkg::ST_IGNORE;
                     unique case (op_reg)
                        eepr_pkg::OP_READ:
                        begin
                           state_reg <= eepr_pkg::ST_READ;
                           read_start_reg <= 1'h1;
                        end
                        eepr_pkg::OP_WRITE:
                        begin
                           state_reg <= eepr_pkg::ST_DATA;
                        end
                        eepr_pkg::OP_ERASE:
                        begin
                           if (we_en_reg)
                           begin
                              launch_reg <= 1'h1;
                              status_armed_reg <= 1'h1;
                              job_reg <= mk_job(1'h0, org_reg, a_next, eepr_pkg::ERASED_WORD);
                           end
                        end
                        eepr_pkg::OP_EXT:
                        begin
                           unique case (ext_code)
                              eepr_pkg::EXT_ENABLE: we_en_reg <= 1'h1;
                              eepr_pkg::EXT_DISABLE: we_en_reg <= 1'h0;
                              eepr_pkg::EXT_WRITE_ALL: state_reg <= eepr_pkg::ST_DATA;
                              eepr_pkg::EXT_ERASE_ALL:
                              begin
                                 if (we_en_reg)
                                 begin
                                    launch_reg <= 1'h1;
                                    status_armed_reg <= 1'h1;
                                    job_reg <= mk_job(1'h1, org_reg, a_next, eepr_pkg::ERASED_WORD);
                                 end
                              end
                           endcase
                        end
                     endcase
                  end
               end
               eepr_pkg::ST_DATA:
               begin
                  data_reg <= d_next;
                  if (data_last)
                  begin
                     state_reg <= eepr_pkg::ST_IGNORE;
                     if (we_en_reg)
                     begin
                        // direct overwrite, no prior erase needed
                        launch_reg <= 1'h1;
                        status_armed_reg <= 1'h1;
                        job_reg <= mk_job(op_reg != eepr_pkg::OP_WRITE, org_reg, addr_reg, d_next);
                     end
                  end
               end
               eepr_pkg::ST_READ, eepr_pkg::ST_IGNORE:
               begin
               end
            endcase
         end
      end
   end

   // self-timed write engine, one byte per cycle, busy for at least WRITE_CYCLES
   assign wr_active = busy_reg && (idx_reg < job_reg.len);
   assign wr_byte = 11'(job_reg.base + idx_reg[10:0]);
   assign wr_val = (job_reg.wide && !wr_byte[0]) ? job_reg.data[15:8] : job_reg.data[7:0];

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         busy_reg <= 1'h0;
         timer_reg <= 32'h0000_0000;
         idx_reg <= 12'h000;
      end
      else if (launch_reg)
      begin
         busy_reg <= 1'h1;
         timer_reg <= 32'(WRITE_CYCLES - 1);
         idx_reg <= 12'h000;
      end
      else if (busy_reg)
      begin
         if (wr_active)
         begin
            idx_reg <= 12'(idx_reg + 12'h001);
         end
         if (timer_reg != 32'h0000_0000)
         begin
            timer_reg <= 32'(timer_reg - 32'h0000_0001);
         end
         else if (!wr_active)
         begin
            busy_reg <= 1'h0;
         end
      end
   end

   // array contents survive reset
   always_ff @(posedge core_clk)
   begin
      if (wr_active)
      begin
         mem_array[wr_byte] <= wr_val;
      end
   end

   // read prefetch into the buffer
   always_comb
   begin
      rd_word.wide = org_reg;
      rd_word.data = org_reg ? {mem_array[{fetch_addr_reg[9:0], 1'h0}], mem_array[{fetch_addr_reg[9:0], 1'h1}]}
                             : {8'h00, mem_array[fetch_addr_reg]};
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n || !device_select)
      begin
         fetch_on_reg <= 1'h0;
         fetch_addr_reg <= 11'h000;
      end
      else if (read_start_reg)
      begin
         fetch_on_reg <= 1'h1;
         fetch_addr_reg <= org_reg ? {1'h0, addr_reg[9:0]} : addr_reg;
      end
      else if (fetch_on_reg && buf_in_ready)
      begin
         // sequential read wraps at the top of the array
         fetch_addr_reg <= org_reg ? {1'h0, 10'(fetch_addr_reg[9:0] + 10'h001)} : 11'(fetch_addr_reg + 11'h001);
      end
   end

   eepr_buf #(
      .WIDTH($bits(eepr_pkg::eepr_word_t)),
      .DEPTH(2)
   ) u_buf (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .flush(!device_select),
      .in_valid(fetch_on_reg),
      .in_ready(buf_in_ready),
      .in_data(rd_word),
      .out_valid(buf_out_valid),
      .out_ready(pop),
      .out_data(buf_out_bits)
   );

   assign buf_word = eepr_pkg::eepr_word_t'(buf_out_bits);
   assign pop = (state_reg == eepr_pkg::ST_READ) && active_edge && (bits_left_reg == 5'h00) && buf_out_valid;

   // output shifter and pin driver
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         serial_out <= 1'h0;
         serial_out_oe <= 1'h0;
         shift_reg <= 16'h0000;
         bits_left_reg <= 5'h00;
      end
      else if (!device_select)
      begin
         serial_out_oe <= 1'h0;
         bits_left_reg <= 5'h00;
      end
      else if (state_reg == eepr_pkg::ST_STATUS)
      begin
         serial_out_oe <= 1'h1;
         serial_out <= !busy_reg;
      end
      else if (state_reg == eepr_pkg::ST_ADDR && active_edge && addr_last && op_reg == eepr_pkg::OP_READ)
      begin
         serial_out_oe <= 1'h1;
         serial_out <= 1'h0;
      end
      else if (state_reg == eepr_pkg::ST_READ)
      begin
         if (pop)
         begin
            serial_out <= buf_word.wide ? buf_word.data[15] : buf_word.data[7];
            shift_reg <= buf_word.wide ? {buf_word.data[14:0], 1'h0} : {buf_word.data[6:0], 9'h000};
            bits_left_reg <= buf_word.wide ? eepr_pkg::BITS_LEFT_X16 : eepr_pkg::BITS_LEFT_X8;
         end
         else if (active_edge && bits_left_reg != 5'h00)
         begin
            serial_out <= shift_reg[15];
            shift_reg <= {shift_reg[14:0], 1'h0};
            bits_left_reg <= 5'(bits_left_reg - 5'h01);
         end
      end
      else
      begin
         serial_out_oe <= 1'h0;
      end
   end

   a_desel_hiz: assert property (@(posedge core_clk) disable iff (!rst_n)
      !device_select |=> !serial_out_oe)
      else $error("output driven while deselected");

   a_desel_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      !device_select |=> state_reg == eepr_pkg::ST_IDLE && !launch_reg)
      else $error("sequencer active while deselected");

   a_start_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_reg == eepr_pkg::ST_IDLE && !cs_rise && active_edge && serial_in && !busy_reg)
      |=> state_reg == eepr_pkg::ST_OP && bit_cnt_reg == 4'h0)
      else $error("start bit not captured");

   a_read_lead: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_reg == eepr_pkg::ST_ADDR && active_edge && addr_last && op_reg == eepr_pkg::OP_READ)
      |=> serial_out_oe && !serial_out && state_reg == eepr_pkg::ST_READ ##1 fetch_on_reg)
      else $error("read not started after address");

   a_status_level: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_reg == eepr_pkg::ST_STATUS && device_select) ##1 device_select
      |-> serial_out_oe && serial_out == !$past(busy_reg))
      else $error("ready/busy level wrong");

   a_refuse_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(launch_reg) |-> $past(we_en_reg))
      else $error("write started while disabled");

   a_write_timed: assert property (@(posedge core_clk) disable iff (!rst_n)
      launch_reg |=> busy_reg [*8] ##0 status_armed_reg)
      else $error("write did not run self-timed");

   a_engine_done: assert property (@(posedge core_clk) disable iff (!rst_n)
      (busy_reg && !launch_reg && timer_reg == 32'h0000_0000 && !wr_active) |=> !busy_reg)
      else $error("busy held after completion");

   a_wide_word: assert property (@(posedge core_clk) disable iff (!rst_n)
      (pop && org_reg) |=> bits_left_reg == eepr_pkg::BITS_LEFT_X16 && serial_out == $past(buf_word.data[15]))
      else $error("16-bit word shifted wrongly");

   a_narrow_word: assert property (@(posedge core_clk) disable iff (!rst_n)
      (pop && !org_reg) |=> bits_left_reg == eepr_pkg::BITS_LEFT_X8 && serial_out == $past(buf_word.data[7]))
      else $error("8-bit word shifted wrongly");

endmodule

`default_nettype wire

// File: rtl/eepr_pkg.sv
// shared constants and types for the three-wire serial memory port
package eepr_pkg;

   // array geometry
   localparam int ARRAY_BYTES = 2048;
   localparam logic [11:0] BULK_LEN = 12'h800;
   localparam logic [11:0] LEN_X16 = 12'h002;
   localparam logic [11:0] LEN_X8 = 12'h001;
   localparam logic [15:0] ERASED_WORD = 16'hffff;

   // last bit index of each field, per organisation
   localparam logic [3:0] OP_LAST = 4'h1;
   localparam logic [3:0] ADDR_LAST_X16 = 4'h9;
   localparam logic [3:0] ADDR_LAST_X8 = 4'ha;
   localparam logic [3:0] DATA_LAST_X16 = 4'hf;
   localparam logic [3:0] DATA_LAST_X8 = 4'h7;
   localparam logic [4:0] BITS_LEFT_X16 = 5'h0f;
   localparam logic [4:0] BITS_LEFT_X8 = 5'h07;

   // two-bit opcodes following the start bit
   localparam logic [1:0] OP_EXT = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_ERASE = 2'h3;

   // sub-codes in the two top address bits under OP_EXT
   localparam logic [1:0] EXT_DISABLE = 2'h0;
   localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
   localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
   localparam logic [1:0] EXT_ENABLE = 2'h3;

   // self-timed write length in core cycles
   localparam int WRITE_CYCLES_DEFAULT = 4000;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OP,
      ST_ADDR,
      ST_DATA,
      ST_READ,
      ST_STATUS,
      ST_IGNORE
   } eepr_state_t;

   // one word on its way from the array to the output shifter
   typedef struct packed {
      logic [15:0] data;
      logic wide;
   } eepr_word_t;

   // one write or erase job handed to the write engine
   typedef struct packed {
      logic [10:0] base;
      logic [11:0] len;
      logic [15:0] data;
      logic wide;
   } eepr_job_t;

endpackage

// File: rtl/eepr_buf.sv
// two-entry word buffer between array fetch and output shifter
`timescale 1ns/1ps
`default_nettype none

module eepr_buf #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic flush,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] slot [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   logic push;
   logic pop;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'h1);
   endfunction

   assign in_ready = count_reg != CW'(DEPTH);
   assign out_valid = count_reg != '0;
   assign out_data = slot[rd_ptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge core_clk)
   begin
      if (push)
      begin
         slot[wr_ptr_reg] <= in_data;
      end
   end

   // flush drops stale prefetch when the frame ends
   always_ff @(posedge core_clk)
   begin
      if (!rst_n || flush)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= bump(wr_ptr_reg);
         end
         if (pop)
         begin
            rd_ptr_reg <= bump(rd_ptr_reg);
         end
         if (push && !pop)
         begin
            count_reg <= CW'(count_reg + 1'h1);
         end
         else if (pop && !push)
         begin
            count_reg <= CW'(count_reg - 1'h1);
         end
      end
   end

endmodule

`default_nettype wire

// File: verif/eepr_master.sv
// behavioural serial master that drives the three-wire link
`timescale 1ns/1ps
`default_nettype none

module eepr_master (
   // clock
   input wire logic core_clk,
   // serial link
   output logic device_select,
   output logic serial_clock,
   output logic serial_in,
   input wire logic pin
);
   initial
   begin
      device_select = 1'h0;
      serial_clock = 1'h0;
      serial_in = 1'h0;
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // deselect time of six core cycles between frames: a five-cycle wait, then the next select waits one more edge
   task automatic select(input logic v);
      @(posedge core_clk);
      device_select <= v;
      serial_in <= ~serial_in;
      wait_cyc(5);
   endtask

   // data settles four cycles ahead of the rise; the reply is read mid-cycle, once it has settled
   task automatic bit_io(input logic b, output logic o);
      serial_in <= b;
      wait_cyc(4);
      serial_clock <= 1'h1;
      wait_cyc(3);
      @(negedge core_clk);
      o = pin;
      @(posedge core_clk);
      serial_clock <= 1'h0;
   endtask

   task automatic send(input logic [31:0] bits, input int n, output logic o);
      for (int i = n - 1; i >= 0; i--)
      begin
         bit_io(bits[i], o);
      end
   endtask

   task automatic recv(input int n, output logic [15:0] d);
      logic o;
      d = 16'h0000;
      repeat (n)
      begin
         bit_io(~serial_in, o);
         d = {d[14:0], o};
      end
   endtask
endmodule

`default_nettype wire

// File: verif/test_three_wire_serial_eeprom_port.sv
// self-checking bench for the serial memory port
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module test_three_wire_serial_eeprom_port;
   logic core_clk = 1'h0;
   logic rst_n = 1'h0;
   logic organisation_select = 1'h1;
   logic device_select;
   logic serial_clock;
   logic serial_in;
   logic serial_out;
   logic serial_out_oe;
   wire serial_pin = serial_out_oe ? serial_out : 1'bz;
   int error_cnt = 0;
   int cmp_count = 0;

   always #25 core_clk = ~core_clk;

   eepr_port #(.WRITE_CYCLES(32)) u_dut (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .device_select(device_select),
      .serial_clock(serial_clock),
      .serial_in(serial_in),
      .serial_out(serial_out),
      .serial_out_oe(serial_out_oe),
      .organisation_select(organisation_select)
   );

   eepr_master u_master (
      .core_clk(core_clk),
      .device_select(device_select),
      .serial_clock(serial_clock),
      .serial_in(serial_in),
      .pin(serial_pin)
   );

   task automatic summarize;
      if (error_cnt == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // every select change passes through here, so the select level reaches the master as a variable
   task automatic link(input logic v);
      u_master.select(v);
   endtask

   task automatic frame(input logic [31:0] bits, input int n);
      logic o;
      link(1'h1);
      u_master.send(bits, n, o);
      link(1'h0);
   endtask

   // reselect after a launch: busy first, ready within a bounded wait; pin read mid-cycle
   task automatic status_check;
      link(1'h1);
      @(negedge core_clk);
      `CHK(serial_pin, 1'h0)
      for (int i = 0; i < 200 && serial_pin !== 1'h1; i++)
         @(negedge core_clk);
      `CHK(serial_pin, 1'h1)
      link(1'h0);
      `CHK(serial_out_oe, 1'h0)
   endtask

   task automatic read_words(input logic [31:0] cmd, input int n, input int w, output logic [15:0] d);
      logic o;
      link(1'h1);
      u_master.send(cmd, n, o);
      `CHK(o, 1'h0)
      u_master.recv(w, d);
   endtask

   task automatic t_write_x16;
      logic [15:0] d;
      organisation_select <= 1'h1;
      frame(32'({1'h1, eepr_pkg::OP_EXT, eepr_pkg::EXT_ENABLE, 8'h00}), 13);
      frame(32'({1'h1, eepr_pkg::OP_WRITE, 10'h155, 16'ha5c3}), 29);
      status_check();
      read_words(32'({1'h1, eepr_pkg::OP_READ, 10'h155}), 13, 16, d);
      link(1'h0);
      `CHK(d, 16'ha5c3)
      frame(32'({1'h1, eepr_pkg::OP_WRITE, 10'h155, 16'h0f1e}), 29);
      status_check();
      read_words(32'({1'h1, eepr_pkg::OP_READ, 10'h155}), 13, 16, d);
      link(1'h0);
      `CHK(d, 16'h0f1e)
   endtask

   // same storage seen byte-wise: high byte at the even address
   task automatic t_x8;
      logic [15:0] d;
      organisation_select <= 1'h0;
      read_words(32'({1'h1, eepr_pkg::OP_READ, 11'h2aa}), 14, 8, d);
      `CHK(d[7:0], 8'h0f)
      u_master.recv(8, d);
      link(1'h0);
      `CHK(d[7:0], 8'h1e)
      frame(32'({1'h1, eepr_pkg::OP_WRITE, 11'h2ab, 8'h77}), 22);
      status_check();
      organisation_select <= 1'h1;
      read_words(32'({1'h1, eepr_pkg::OP_READ, 10'h155}), 13, 16, d);
      link(1'h0);
      `CHK(d, 16'h0f77)
   endtask

   task automatic t_erase;
      logic [15:0] d;
      frame(32'({1'h1, eepr_pkg::OP_ERASE, 10'h155}), 13);
      status_check();
      read_words(32'({1'h1, eepr_pkg::OP_READ, 10'h155}), 13, 16, d);
      link(1'h0);
      `CHK(d, eepr_pkg::ERASED_WORD)
   endtask

   task automatic t_disabled;
      logic [15:0] d;
      frame(32'({1'h1, eepr_pkg::OP_EXT, eepr_pkg::EXT_DISABLE, 8'h00}), 13);
      frame(32'({1'h1, eepr_pkg::OP_WRITE, 10'h155, 16'h1234}), 29);
      link(1'h1);
      `CHK(serial_out_oe, 1'h0)
      link(1'h0);
      read_words(32'({1'h1, eepr_pkg::OP_READ, 10'h155}), 13, 16, d);
      link(1'h0);
      `CHK(d, eepr_pkg::ERASED_WORD)
   endtask

   // traffic while deselected must neither enable nor answer
   task automatic t_deselected;
      logic o;
      logic [15:0] d;
      u_master.send(32'({1'h1, eepr_pkg::OP_EXT, eepr_pkg::EXT_ENABLE, 8'h00}), 13, o);
      u_master.send(32'({1'h1, eepr_pkg::OP_READ, 10'h155}), 13, o);
      `CHK(serial_out_oe, 1'h0)
      frame(32'({1'h1, eepr_pkg::OP_WRITE, 10'h155, 16'h4321}), 29);
      read_words(32'({1'h1, eepr_pkg::OP_READ, 10'h155}), 13, 16, d);
      link(1'h0);
      `CHK(d, eepr_pkg::ERASED_WORD)
   endtask

   initial
   begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'h1;
      repeat (2) @(posedge core_clk);
      `CHK(serial_out_oe, 1'h0)
      t_write_x16();
      t_x8();
      t_erase();
      t_disabled();
      t_deselected();
      summarize();
   end

   initial
   begin
      #2_000_000;
      error_cnt++;
      summarize();
   end
endmodule

`default_nettype wire
